// ===== rtl/fault_monitor_latch.sv
// Health-flag monitor: stretches fault pulses, latches errors, runs the guarded recovery.
// Assumes a serial front end that decodes commands into one-cycle pulses and routes rate reads.
`timescale 1ns/1ps
`default_nettype none
`include "fault_monitor_defines.svh"

module fault_monitor_latch
	import fault_monitor_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire fault_inputs_t faults,
	input wire cmd_pulses_t cmds,
	input wire logic startup_done,
	output logic [7:0] health_flags,
	output logic status_valid,
	output logic error_code_sel,
	output logic dsp_hold,
	output logic guard_enabled
);

	// ****************************************
	// Raw flags, active low
	// ****************************************
	// Bit 0 is tied high; test flag still reported but filtered later
	wire [7:0] raw_ok = {~faults.adc_overflow, ~faults.dsp_arith_fault, ~faults.trim_parity_fail,
		~faults.analog_test_on, ~faults.supply_out_of_range, ~faults.pickoff_fault,
		~faults.drive_unlocked, 1'b1};

	// ****************************************
	// Pulse stretchers, one per flag
	// ****************************************
	// Short pulses must survive long enough for a polling host to see them
	logic [7:0] stretched_ok;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_stretch
			logic [18:0] hold_cnt;
			wire hold_busy = (hold_cnt != 19'h00000);
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					hold_cnt <= 19'h00000;
				end else if (!raw_ok[gi]) begin
					hold_cnt <= 19'(`STRETCH_CYCLES);
				end else if (hold_busy) begin
					hold_cnt <= hold_cnt - 19'h00001;
				end
			end
			assign stretched_ok[gi] = raw_ok[gi] & ~hold_busy;
		end
	endgenerate

	// ****************************************
	// Fault guard sequence
	// ****************************************
	// Steps must come in order; an out-of-order step or enable restarts it, a repeat of the last step is ignored
	guard_state_t guard_state;
	guard_state_t next_guard_state;
	always_comb begin
		next_guard_state = guard_state;
		case (guard_state)
			GUARD_ON: begin
				if (cmds.guard_off_step_one_cmd) next_guard_state = GUARD_STEP1;
			end
			GUARD_STEP1: begin
				if (cmds.guard_off_step_two_cmd) next_guard_state = GUARD_STEP2;
				else if (cmds.guard_off_step_three_cmd || cmds.guard_on_cmd) next_guard_state = GUARD_ON;
			end
			GUARD_STEP2: begin
				if (cmds.guard_off_step_three_cmd) next_guard_state = GUARD_OFF;
				else if (cmds.guard_off_step_one_cmd || cmds.guard_on_cmd) next_guard_state = GUARD_ON;
			end
			GUARD_OFF: begin
				if (cmds.guard_on_cmd) next_guard_state = GUARD_ON;
			end
			default: next_guard_state = GUARD_ON;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			guard_state <= GUARD_ON;
		end else begin
			guard_state <= next_guard_state;
		end
	end

	wire guard_off = (guard_state == GUARD_OFF);
	wire recover_go = cmds.fault_recover_cmd & guard_off;

	// ****************************************
	// Error latch
	// ****************************************
	// Latch only once start-up is over and while the guard is on
	wire [7:0] bad_now = ~stretched_ok & `LATCHING_MASK;
	wire latch_open = startup_done & ~guard_off;
	logic [7:0] latched_bad;
	// Fatal bits are only remembered across recovery; they re-arm on re-enable
	logic [7:0] fatal_memo;
	logic [7:0] next_latched_bad;
	always_comb begin
		next_latched_bad = latched_bad;
		if (recover_go) begin
			next_latched_bad = latched_bad & ~`RECOVERABLE_MASK;
		end
		if (guard_state == GUARD_OFF && cmds.guard_on_cmd) begin
			next_latched_bad = next_latched_bad | fatal_memo;
		end
		if (latch_open) begin
			next_latched_bad = next_latched_bad | bad_now;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			latched_bad <= 8'h00;
			fatal_memo <= 8'h00;
		end else begin
			latched_bad <= next_latched_bad;
			if (guard_state == GUARD_ON && next_guard_state == GUARD_STEP1) begin
				fatal_memo <= latched_bad & ~`RECOVERABLE_MASK;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Pickoff fault forces the error code only while its stretched flag is low
	wire pickoff_now = startup_done & ~stretched_ok[`BIT_PICKOFF];
	wire latched_any = (latched_bad != 8'h00);
	assign error_code_sel = ~startup_done | latched_any | pickoff_now;
	assign dsp_hold = latched_any;
	assign guard_enabled = ~guard_off;

	// Status read is a plain sample; nothing is cleared by it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			health_flags <= `FLAGS_RESET;
			status_valid <= 1'b0;
		end else begin
			status_valid <= cmds.status_read_cmd;
			if (cmds.status_read_cmd) begin
				health_flags <= stretched_ok;
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	a_spare_bit_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
		status_valid |-> health_flags[`BIT_SPARE]) else $error("spare bit read low");
	a_test_no_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(latched_bad[`BIT_TEST] == 1'b0)) else $error("test flag latched");
	a_pre_start_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!startup_done |-> error_code_sel) else $error("rate data before start-up");
	a_fault_latches: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(latch_open && faults.adc_overflow && !recover_go) |=> dsp_hold) else $error("fault not latched");
	a_pickoff_no_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(latch_open && faults.pickoff_fault) |=> !latched_bad[`BIT_PICKOFF]) else $error("pickoff latched");
	a_recover_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.fault_recover_cmd && !guard_off) |=> latched_bad[`BIT_ADC] >= $past(latched_bad[`BIT_ADC]))
		else $error("recovery without guard off");
	a_no_latch_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(guard_off && $past(guard_off) && !cmds.guard_on_cmd) |=> !$rose(latched_bad[`BIT_ADC]))
		else $error("latched while guard off");
	a_stretch_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		faults.drive_unlocked |=> !stretched_ok[`BIT_DRIVE] [*8]) else $error("pulse not stretched");
	a_read_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && !recover_go && !latch_open && !(guard_off && cmds.guard_on_cmd))
		|=> latched_bad == $past(latched_bad)) else $error("read altered latch");

	// ****************************************
	// Assertion helpers
	// ****************************************
	// Cycles the drive flag has stayed low since its fault went away.
	// The whole span outlasts any short run, so only its upper bound is watched.
	logic [18:0] tail_run;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tail_run <= 19'h00000;
		end else if (raw_ok[`BIT_DRIVE] && !stretched_ok[`BIT_DRIVE]) begin
			tail_run <= tail_run + 19'h00001;
		end else begin
			tail_run <= 19'h00000;
		end
	end

	// Guard-off steps on consecutive pulses, starting from the guarded state
	sequence s_guard_steps;
		(guard_state == GUARD_ON && cmds.guard_off_step_one_cmd) ##1 cmds.guard_off_step_two_cmd
			##1 cmds.guard_off_step_three_cmd;
	endsequence

	// Guard re-enabled out of the fully disabled state
	sequence s_guard_back;
		guard_off && cmds.guard_on_cmd;
	endsequence

	// Recovery command honoured while the guard is off
	sequence s_recover_taken;
		guard_off && cmds.fault_recover_cmd;
	endsequence

	// ****************************************
	// Flags in the status word
	// ****************************************
	// A source active at the read edge must show low in the word that follows
	a_adc_flag_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && faults.adc_overflow) |=> !health_flags[`BIT_ADC])
		else $error("converter flag not low");
	a_dsp_flag_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && faults.dsp_arith_fault) |=> !health_flags[`BIT_DSP])
		else $error("arithmetic flag not low");
	a_trim_flag_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && faults.trim_parity_fail) |=> !health_flags[`BIT_TRIM])
		else $error("trim parity flag not low");
	a_test_flag_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && faults.analog_test_on) |=> !health_flags[`BIT_TEST])
		else $error("test flag not low");
	a_supply_flag_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && faults.supply_out_of_range) |=> !health_flags[`BIT_SUPPLY])
		else $error("supply flag not low");
	a_pickoff_flag_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && faults.pickoff_fault) |=> !health_flags[`BIT_PICKOFF])
		else $error("pickoff flag not low");
	a_drive_flag_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && faults.drive_unlocked) |=> !health_flags[`BIT_DRIVE])
		else $error("drive flag not low");
	// The answer to a read is a one-cycle strobe, never a stray one
	a_valid_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmds.status_read_cmd |=> status_valid)
		else $error("status strobe missing");
	a_valid_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!cmds.status_read_cmd |=> !status_valid)
		else $error("stray status strobe");

	// ****************************************
	// Error latch
	// ****************************************
	// Each latching source sets its own bit at the next edge while the latch is open
	a_dsp_latches: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(latch_open && faults.dsp_arith_fault) |=> latched_bad[`BIT_DSP])
		else $error("arithmetic fault not latched");
	a_trim_latches: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(latch_open && faults.trim_parity_fail) |=> latched_bad[`BIT_TRIM])
		else $error("trim parity fault not latched");
	a_supply_latches: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(latch_open && faults.supply_out_of_range) |=> latched_bad[`BIT_SUPPLY])
		else $error("supply fault not latched");
	a_drive_latches: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(latch_open && faults.drive_unlocked) |=> latched_bad[`BIT_DRIVE])
		else $error("drive fault not latched");
	// A held processing chain always comes with the error code on rate reads
	a_hold_has_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dsp_hold |-> error_code_sel)
		else $error("hold without error code");
	// A present pickoff fault selects the error code once start-up is over
	a_pickoff_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(startup_done && faults.pickoff_fault) |-> error_code_sel)
		else $error("pickoff fault without error code");
	// Recovery clears the recoverable bits only; fatal bits stay put
	a_recover_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_recover_taken |=> ((latched_bad & `RECOVERABLE_MASK) == 8'h00))
		else $error("recoverable fault not cleared");
	a_fatal_stays: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(recover_go && latched_bad[`BIT_TRIM]) |=> latched_bad[`BIT_TRIM])
		else $error("fatal fault cleared by recovery");

	// ****************************************
	// Guard and recovery
	// ****************************************
	// Three steps in order fully disable the guard
	a_guard_opens: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_guard_steps |=> guard_off)
		else $error("guard not disabled by three steps");
	// The enable command brings guarded operation back at once
	a_guard_closes: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_guard_back |=> guard_enabled)
		else $error("guard not re-enabled");
	// Fatal bits seen before step one come back with the guard
	a_fatal_restored: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_guard_back |=> ((latched_bad & $past(fatal_memo)) == $past(fatal_memo)))
		else $error("fatal fault not restored");
	// The memory of fatal bits is taken as the guard starts to open
	a_memo_taken: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(guard_state == GUARD_ON && cmds.guard_off_step_one_cmd)
		|=> (fatal_memo == ($past(latched_bad) & ~`RECOVERABLE_MASK))) else $error("fatal bits not kept");
	// No new bit may appear while the guard stays off
	a_no_rise_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(guard_off && !cmds.guard_on_cmd) |=> ((latched_bad & ~$past(latched_bad)) == 8'h00))
		else $error("new error latched while guard off");
	// A read never takes a latched error away
	a_read_no_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(cmds.status_read_cmd && !recover_go && latched_any) |=> latched_any)
		else $error("read cleared a latched error");
	// Stretcher bounds: still low just after the fault, never longer than the span
	a_stretch_tail: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(raw_ok[`BIT_DRIVE] && $past(!raw_ok[`BIT_DRIVE] && !sys_rst)) |-> !stretched_ok[`BIT_DRIVE])
		else $error("flag released right after fault");
	a_stretch_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tail_run <= 19'(`STRETCH_CYCLES))
		else $error("flag stretched too long");

endmodule
`default_nettype wire

// ===== rtl/fault_monitor_defines.svh
// Constants of the health-flag monitor: bit positions, reset values, timing counts.
// Assumes inclusion by bare name from the design module.
// Contract
// - Bit 7 low on converter overflow, recoverable
// - Bit 6 low on arithmetic fault, fatal
// - Bit 5 low on trim parity failure, fatal
// - Bit 4 low in analog test, never errors
// - Bit 3 low when supply out of window
// - Bit 2 low on faulty pickoff connection
// - Bit 1 low when drive loop unlocked, recoverable
// - Bit 0 unused, always reads one
// - Error code on rate reads before start-up
// - After start-up, flag low gives error, hold
// - Error latched till power-down or recovery
// - Pickoff flag errors only while present, unlatched
// - Recovery acts only after three guard-off steps
// - Fatal fault before guard-off returns on re-enable
// - No latching while guard is disabled
// - Low pulses stretched to 1.5 to 2 ms
// - Status read returns flags; host reads within 1.5ms
`ifndef FAULT_MONITOR_DEFINES_SVH
`define FAULT_MONITOR_DEFINES_SVH

// ****************************************
// Flag positions
// ****************************************
`define BIT_ADC 7
`define BIT_DSP 6
`define BIT_TRIM 5
`define BIT_TEST 4
`define BIT_SUPPLY 3
`define BIT_PICKOFF 2
`define BIT_DRIVE 1
`define BIT_SPARE 0
`define FLAGS_RESET 8'hFF
// Recoverable sources: converter overflow and drive loop
`define RECOVERABLE_MASK 8'h82
// Sources that latch the error: all but test, pickoff, spare
`define LATCHING_MASK 8'hEA

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 5
// Stretch span 1.5 ms as least time, rounded up to cycles
`define STRETCH_NS 1500000
`define STRETCH_CYCLES ((`STRETCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/fault_monitor_pkg.sv
// Types shared by the health-flag monitor.
// Assumes the defines header is on the include path.
package fault_monitor_pkg;
	// Raw health conditions, each high when the fault is present
	typedef struct packed {
		logic adc_overflow;
		logic dsp_arith_fault;
		logic trim_parity_fail;
		logic analog_test_on;
		logic supply_out_of_range;
		logic pickoff_fault;
		logic drive_unlocked;
	} fault_inputs_t;

	// Commands decoded by the serial front end, each a one-cycle pulse
	typedef struct packed {
		logic status_read_cmd;
		logic guard_off_step_one_cmd;
		logic guard_off_step_two_cmd;
		logic guard_off_step_three_cmd;
		logic guard_on_cmd;
		logic fault_recover_cmd;
	} cmd_pulses_t;

	// Guard disable sequence, Gray coded along the usual path
	typedef enum logic [1:0] {
		GUARD_ON = 2'b00,
		GUARD_STEP1 = 2'b01,
		GUARD_STEP2 = 2'b11,
		GUARD_OFF = 2'b10
	} guard_state_t;
endpackage

// ===== test/host_model.sv
// Host model: plays serial command sequences to the monitor as one-cycle pulses.
// Assumes the monitor decodes cmd_pulses_t pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module host_model
	import fault_monitor_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [2:0] seq,
	input wire logic start,
	output var cmd_pulses_t cmds,
	output logic busy
);
	// ****************************************
	// Sequence table
	// ****************************************
	// Status read, guard-off steps, recover, guard on; the 1 s settling wait is skipped to keep runs short
	localparam logic [5:0] ROM [0:5] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h01, 6'h02};
	logic [2:0] idx;
	logic [2:0] last;
	// Codes: 0 read, 1 guard off, 2 recover, 3 guard on, 4 full recovery
	wire logic [2:0] first = (seq == 3'h1 || seq == 3'h4) ? 3'h1 : (seq == 3'h2) ? 3'h4 : (seq == 3'h3) ? 3'h5 : 3'h0;
	wire logic [2:0] stop = (seq == 3'h1) ? 3'h3 : (seq == 3'h2) ? 3'h4 : (seq >= 3'h3) ? 3'h5 : 3'h0;
	// One command per cycle, so in full recovery the guard is off only for a few cycles
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			busy <= 1'b0;
		end else if (start && !busy) begin
			busy <= 1'b1;
			idx <= first;
			last <= stop;
		end else if (busy && idx == last) begin
			busy <= 1'b0;
		end else if (busy) begin
			idx <= idx + 3'h1;
		end
		cmds <= (busy && !sys_rst) ? cmd_pulses_t'(ROM[idx]) : '0;
	end
endmodule
`default_nettype wire

// ===== test/fault_monitor_latch_bench.sv
// Testbench of the health-flag monitor: per-source table, then start-up, recovery and guard cases.
// Assumes the host model plays commands; faults are driven here directly.
`timescale 1ns/1ps
`default_nettype none
module fault_monitor_latch_bench
	import fault_monitor_pkg::*;
;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic startup_done = 1'b0;
	logic start = 1'b0;
	logic [2:0] seq = 3'h0;
	fault_inputs_t faults = '0;
	cmd_pulses_t cmds;
	logic [7:0] health_flags;
	logic status_valid, error_code_sel, dsp_hold, guard_enabled, busy;
	int n_fail = 0;
	int num_checks = 0;
	// Fault, expected flags, hold, error select
	logic [16:0] rows [8] = '{{7'h40, 8'h7F, 2'b11}, {7'h20, 8'hBF, 2'b11}, {7'h10, 8'hDF, 2'b11},
		{7'h08, 8'hEF, 2'b00}, {7'h04, 8'hF7, 2'b11}, {7'h02, 8'hFB, 2'b01}, {7'h01, 8'hFD, 2'b11},
		{7'h00, 8'hFF, 2'b00}};

	fault_monitor_latch dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .faults(faults), .cmds(cmds),
		.startup_done(startup_done), .health_flags(health_flags), .status_valid(status_valid),
		.error_code_sel(error_code_sel), .dsp_hold(dsp_hold), .guard_enabled(guard_enabled));
	host_model host (.clk_sys(clk_sys), .sys_rst(sys_rst), .seq(seq), .start(start), .cmds(cmds), .busy(busy));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		if (n_fail == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic do_reset(input logic up);
		@(posedge clk_sys) sys_rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		startup_done <= up;
	endtask
	// Short fault pulse; the stretcher must keep it visible afterwards
	task automatic hit(input fault_inputs_t f);
		@(posedge clk_sys) faults <= f;
		repeat (2) @(posedge clk_sys);
		faults <= '0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	// Bounded wait on the host model, sampled clear of the edge
	task automatic run(input logic [2:0] s);
		@(posedge clk_sys);
		seq <= s;
		start <= 1'b1;
		@(posedge clk_sys) start <= 1'b0;
		#1;
		for (int i = 0; i < 10 && busy !== 1'b0; i++) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		#1;
		if (s == 3'h0) chk({7'h0, status_valid}, 8'h01);
		@(posedge clk_sys);
		#1;
	endtask

	// ****************************************
	// Clock, watchdog and sequence
	// ****************************************
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		n_fail++;
		end_of_test();
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			do_reset(1'b1);
			hit(rows[i][16:10]);
			chk({7'h0, dsp_hold}, {7'h0, rows[i][1]});
			chk({7'h0, error_code_sel}, {7'h0, rows[i][0]});
			run(3'h0);
			chk(health_flags, rows[i][9:2]);
			run(3'h0);
			chk(health_flags, rows[i][9:2]);
		end
		// Before start-up the error code is selected and nothing latches
		do_reset(1'b0);
		hit(7'h40);
		chk({7'h0, error_code_sel}, 8'h01);
		chk({7'h0, dsp_hold}, 8'h00);
		// Recovery ignored while guarded, honoured once the guard is off
		do_reset(1'b1);
		hit(7'h40);
		run(3'h2);
		chk({7'h0, dsp_hold}, 8'h01);
		run(3'h1);
		chk({7'h0, guard_enabled}, 8'h00);
		run(3'h2);
		chk({7'h0, dsp_hold}, 8'h00);
		hit(7'h20);
		chk({7'h0, dsp_hold}, 8'h00);
		// Fatal fault from before guard-off comes back with the guard
		do_reset(1'b1);
		hit(7'h10);
		run(3'h4);
		chk({7'h0, guard_enabled}, 8'h01);
		chk({7'h0, dsp_hold}, 8'h01);
		end_of_test();
	end
endmodule
`default_nettype wire
